// >>> tbw_pkg.sv
// Constants, register map and bus carrier for the timebase/watchdog/capture.
// Assumes a byte-wide register port; the core clock is the oscillator.
package tbw_pkg;

    // Register byte addresses
    localparam logic [7:0] CSR_ADDR = 8'h0B;
    localparam logic [7:0] CAP_ADDR = 8'h0C;

    // Control/status bit positions
    localparam int CSR_CAP_IE = 7;
    localparam int CSR_CAP_FLAG = 6;
    localparam int CSR_PERIOD_SEL = 5;
    localparam int CSR_TB_IE = 4;
    localparam int CSR_TB_FLAG = 3;
    localparam int CSR_FORCE_RST = 2;
    localparam int CSR_WDG_EN = 1;
    localparam int CSR_WDG_DELAY = 0;

    // Reset values
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam logic [7:0] CAP_RESET = 8'h00;
    localparam logic [7:0] CNT_RESET = 8'h00;

    // Timing: oscillator cycles per count, last count before wrap
    localparam int PRESCALE_DEF = 32;
    localparam logic [7:0] CNT_WRAP = 8'hF9;
    // Short period in oscillator cycles, long period is twice that
    localparam int TB_PERIOD_OSC = 8000;
    localparam int TB_LONG_OSC = 16000;
    // Watchdog period of 2 ms nominal, in counter overflows
    localparam logic [1:0] WDG_OVFS = 2'h2;
    // Delay before the watchdog resumes after wake from halt
    localparam int HALT_RESUME_CYC = 256;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tbw_bus_type;

endpackage : tbw_pkg

// >>> tbw_timer.sv
// Timebase counter, watchdog and input capture with a byte register port.
// Assumes all inputs are synchronous to core_clk, which is the oscillator.
//
// Contract
// R1 - Counter starts at zero, counts every 32 clocks
// R2 - Overflow when counter wraps from F9h to 00h
// R3 - Period select doubles timebase period to 16000
// R4 - Timebase sets flag, irq if enabled, read clears
// R5 - Writes never change the timebase flag
// R6 - Enabled watchdog resets after 2ms without delay
// R7 - Hardware clears delay bit each watchdog period
// R8 - Period counts from reset; late enable resets
// R9 - Software enables early or sets delay first
// R10 - Force bit with watchdog enabled resets device
// R11 - Status reads 1 after watchdog reset
// R12 - Leftover status bit resets on next enable
// R13 - Hardware option keeps watchdog always active
// R14 - Halt stops counter and watchdog resets
// R15 - Wake resumes watchdog after 256 clocks
// R16 - Reset-on-halt option resets on halt entry
// R17 - Software refreshes watchdog before halt
// R18 - Capture edge latches counter, sets flag, irq
// R19 - Set flag blocks captures; read clears it
// R20 - Software reads capture once at init
// R21 - Counter runs except in halt; no halt wake (here the counter also stays frozen during the 256-clock wake delay)
// R22 - Two separate gated interrupt outputs
//
// Design decision made here: the plain strobed port.
`timescale 1ns/1ps
module tbw_timer #(
    parameter int PRESCALE = tbw_pkg::PRESCALE_DEF
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic low_voltage_reset,
    input wire tbw_pkg::tbw_bus_type bus,
    output logic [7:0] rd_data,
    input wire logic capture_input_pin,
    input wire logic hw_watchdog_opt,
    input wire logic reset_on_halt_opt,
    input wire logic halt_enter,
    input wire logic ext_wake,
    output logic timebase_irq,
    output logic capture_irq,
    output logic watchdog_reset
);

    localparam int PW = $clog2(PRESCALE);
    localparam int RW = $clog2(tbw_pkg::HALT_RESUME_CYC + 1);

    function automatic logic hit(input tbw_pkg::tbw_bus_type b,
                                 input logic [7:0] a);
        hit = (b.addr == a);
    endfunction : hit

    logic csr_wr;
    logic csr_rd;
    logic cap_rd;
    assign csr_wr = bus.wr && hit(bus, tbw_pkg::CSR_ADDR);
    assign csr_rd = bus.rd && hit(bus, tbw_pkg::CSR_ADDR);
    assign cap_rd = bus.rd && hit(bus, tbw_pkg::CAP_ADDR);

    logic [PW-1:0] pre_reg;
    logic [7:0] cnt_reg;
    logic halted_reg;
    logic [RW-1:0] resume_reg;
    logic ovf_odd_reg;
    logic cap_ie_reg;
    logic cap_flag_reg;
    logic period_sel_reg;
    logic tb_ie_reg;
    logic tb_flag_reg;
    logic force_flag_reg;
    logic wdg_en_reg;
    logic wdg_delay_reg;
    logic rd_seen_reg;
    logic expired_reg;
    logic active_prev_reg;
    logic [1:0] wdg_ovf_reg;
    logic [7:0] cap_reg;
    logic pin_prev_reg;
    logic [7:0] rd_data_reg;
    logic tb_irq_reg;
    logic cap_irq_reg;
    logic wdg_rst_reg;

    logic running;
    logic tick;
    logic ovf;
    logic tb_event;
    logic wdg_active;
    logic period_end;
    logic delay_wr;
    logic enable_edge;
    logic cap_edge;
    logic wdg_fire;

    // Counter frozen in halt and while the wake delay runs
    assign running = !halted_reg && (resume_reg == '0); // R14 R21
    assign tick = running && (pre_reg == PW'(PRESCALE - 1)); // R1
    assign ovf = tick && (cnt_reg == tbw_pkg::CNT_WRAP); // R2
    assign tb_event = ovf && (!period_sel_reg || ovf_odd_reg); // R3
    assign wdg_active = hw_watchdog_opt || wdg_en_reg; // R13
    assign period_end = ovf && (wdg_ovf_reg == tbw_pkg::WDG_OVFS - 2'h1);
    assign delay_wr = csr_wr && bus.wdata[tbw_pkg::CSR_WDG_DELAY];
    assign enable_edge = wdg_active && !active_prev_reg;
    assign cap_edge = (capture_input_pin != pin_prev_reg); // R18

    always_comb begin
        wdg_fire = 1'b0;
        if (period_end && !wdg_delay_reg && wdg_active) begin
            wdg_fire = 1'b1; // R6
        end
        if (expired_reg && wdg_active) begin
            wdg_fire = 1'b1; // R8
        end
        if (enable_edge && force_flag_reg) begin
            wdg_fire = 1'b1; // R12
        end
        if (csr_wr && bus.wdata[tbw_pkg::CSR_FORCE_RST] && wdg_active) begin
            wdg_fire = 1'b1; // R10
        end
        if (halt_enter && reset_on_halt_opt && wdg_active) begin
            wdg_fire = 1'b1; // R16
        end
    end

    // Prescaler and 8-bit counter
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pre_reg <= '0;
            cnt_reg <= tbw_pkg::CNT_RESET;
        end else if (running) begin
            pre_reg <= tick ? '0 : pre_reg + PW'(1); // R1
            if (ovf) begin
                cnt_reg <= 8'h00; // R2
            end else if (tick) begin
                cnt_reg <= cnt_reg + 8'h01;
            end
        end
    end

    // Halt entry, wake and the resume delay
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            halted_reg <= 1'b0; // R15
            resume_reg <= '0;
        end else if (halted_reg) begin
            if (ext_wake) begin
                halted_reg <= 1'b0;
                resume_reg <= RW'(tbw_pkg::HALT_RESUME_CYC); // R15
            end
        end else if (halt_enter && !(reset_on_halt_opt && wdg_active)) begin
            halted_reg <= 1'b1; // R14
        end else if (resume_reg != '0) begin
            resume_reg <= resume_reg - RW'(1);
        end
    end

    // Timebase flag and period phase
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ovf_odd_reg <= 1'b0;
            tb_flag_reg <= 1'b0;
        end else begin
            if (ovf) begin
                ovf_odd_reg <= !ovf_odd_reg;
            end
            // Set beats the read clear; writes leave the flag alone
            if (tb_event) begin
                tb_flag_reg <= 1'b1; // R4 R5
            end else if (csr_rd) begin
                tb_flag_reg <= 1'b0; // R4
            end
        end
    end

    // Software control bits
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cap_ie_reg <= tbw_pkg::CSR_RESET[tbw_pkg::CSR_CAP_IE];
            period_sel_reg <= tbw_pkg::CSR_RESET[tbw_pkg::CSR_PERIOD_SEL];
            tb_ie_reg <= tbw_pkg::CSR_RESET[tbw_pkg::CSR_TB_IE];
            wdg_en_reg <= tbw_pkg::CSR_RESET[tbw_pkg::CSR_WDG_EN]; // R15
        end else if (csr_wr) begin
            cap_ie_reg <= bus.wdata[tbw_pkg::CSR_CAP_IE];
            period_sel_reg <= bus.wdata[tbw_pkg::CSR_PERIOD_SEL];
            tb_ie_reg <= bus.wdata[tbw_pkg::CSR_TB_IE];
            wdg_en_reg <= bus.wdata[tbw_pkg::CSR_WDG_EN];
        end
    end

    // Watchdog period, delay bit and late-enable tracking
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wdg_ovf_reg <= 2'h0;
            wdg_delay_reg <= tbw_pkg::CSR_RESET[tbw_pkg::CSR_WDG_DELAY];
            expired_reg <= 1'b0;
            active_prev_reg <= 1'b0;
        end else begin
            active_prev_reg <= wdg_active;
            // Setting the delay restarts the period so 2 ms are granted
            if (delay_wr) begin
                wdg_ovf_reg <= 2'h0;
                wdg_delay_reg <= 1'b1;
                expired_reg <= 1'b0;
            end else if (period_end) begin
                wdg_ovf_reg <= 2'h0;
                wdg_delay_reg <= 1'b0; // R7
                if (!wdg_delay_reg && !wdg_active) begin
                    expired_reg <= 1'b1; // R8
                end
            end else if (ovf) begin
                wdg_ovf_reg <= wdg_ovf_reg + 2'h1; // R8
            end
        end
    end

    // Reset status survives the device reset, cleared by low voltage or by a write of 0 after a read
    always_ff @(posedge core_clk or posedge low_voltage_reset) begin
        if (low_voltage_reset) begin
            force_flag_reg <= 1'b0; // R11
            rd_seen_reg <= 1'b0;
        end else begin
            if (csr_rd) begin
                rd_seen_reg <= 1'b1;
            end else if (csr_wr) begin
                rd_seen_reg <= 1'b0;
            end
            if (wdg_fire) begin
                force_flag_reg <= 1'b1; // R11
            end else if (csr_wr && rd_seen_reg &&
                         !bus.wdata[tbw_pkg::CSR_FORCE_RST]) begin
                force_flag_reg <= 1'b0; // R11
            end
        end
    end

    // Input capture
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pin_prev_reg <= 1'b0;
            cap_reg <= tbw_pkg::CAP_RESET;
            cap_flag_reg <= tbw_pkg::CSR_RESET[tbw_pkg::CSR_CAP_FLAG];
        end else begin
            pin_prev_reg <= capture_input_pin;
            // A pending flag blocks the capture, so no set/clear clash
            if (cap_edge && !cap_flag_reg) begin
                cap_reg <= cnt_reg; // R18
                cap_flag_reg <= 1'b1; // R18
            end else if (cap_rd) begin
                cap_flag_reg <= 1'b0; // R19
            end
        end
    end

    // Read data, one cycle after the strobe; counter is never visible
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_data_reg <= 8'h00;
        end else if (csr_rd) begin
            rd_data_reg <= {cap_ie_reg, cap_flag_reg, period_sel_reg,
                            tb_ie_reg, tb_flag_reg, force_flag_reg,
                            wdg_en_reg, wdg_delay_reg}; // R1
        end else if (cap_rd) begin
            rd_data_reg <= cap_reg;
        end else begin
            rd_data_reg <= 8'h00;
        end
    end

    // Interrupt requests and watchdog reset pulse
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tb_irq_reg <= 1'b0;
            cap_irq_reg <= 1'b0;
            wdg_rst_reg <= 1'b0;
        end else begin
            tb_irq_reg <= tb_flag_reg && tb_ie_reg; // R22
            cap_irq_reg <= cap_flag_reg && cap_ie_reg; // R22
            wdg_rst_reg <= wdg_fire;
        end
    end

    assign rd_data = rd_data_reg;
    assign timebase_irq = tb_irq_reg;
    assign capture_irq = cap_irq_reg;
    assign watchdog_reset = wdg_rst_reg;

    default clocking chk_cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    chk_cnt_wrap: assert property (ovf |=> cnt_reg == 8'h00) // R2
        else $error("counter did not wrap to zero");
    chk_pre_tick: assert property (tick && !ovf |=> pre_reg == '0 && // R1
        cnt_reg == $past(cnt_reg) + 8'h01)
        else $error("counter step or prescale restart wrong");
    chk_tb_period: assert property (tb_event && period_sel_reg |-> // R3
        ovf && ovf_odd_reg)
        else $error("long period event on wrong overflow");
    chk_tb_flag: assert property (tb_event |=> tb_flag_reg ##1 // R4
        tb_irq_reg == $past(tb_ie_reg))
        else $error("timebase flag or irq missing");
    chk_tb_write: assert property (csr_wr && !tb_event |=> // R5
        tb_flag_reg == $past(tb_flag_reg))
        else $error("write changed timebase flag");
    chk_wdg_timeout: assert property (period_end && wdg_active && // R6
        !wdg_delay_reg |=> watchdog_reset)
        else $error("watchdog timeout without reset");
    chk_delay_clear: assert property (period_end && !delay_wr |=> // R7
        !wdg_delay_reg)
        else $error("delay bit survived period end");
    chk_late_enable: assert property (expired_reg && wdg_active |=> // R8
        watchdog_reset)
        else $error("late enable did not reset");
    chk_force_reset: assert property (csr_wr && wdg_active && // R10 R11
        bus.wdata[tbw_pkg::CSR_FORCE_RST] |=>
        watchdog_reset && force_flag_reg)
        else $error("forced reset missing");
    chk_hw_option: assert property (hw_watchdog_opt && !wdg_en_reg && // R13
        period_end && !wdg_delay_reg |=> watchdog_reset)
        else $error("hardware watchdog did not time out");
    chk_halt_freeze: assert property (halted_reg |=> // R14 R21
        $stable(cnt_reg) && !ovf)
        else $error("counter moved in halt");
    chk_resume_wait: assert property (halted_reg && ext_wake |=> // R15
        !running [*8])
        else $error("watchdog resumed too early");
    chk_halt_reset: assert property (halt_enter && reset_on_halt_opt && // R16
        wdg_active |=> watchdog_reset && !halted_reg)
        else $error("halt did not reset");
    chk_cap_latch: assert property (cap_edge && !cap_flag_reg |=> // R18
        cap_flag_reg && cap_reg == $past(cnt_reg))
        else $error("capture not latched");
    chk_cap_hold: assert property (cap_flag_reg |=> $stable(cap_reg)) // R19
        else $error("capture overwritten while flag set");
    chk_cap_clear: assert property (cap_flag_reg && cap_rd |=> // R19
        !cap_flag_reg ##1 !capture_irq)
        else $error("capture flag not cleared by read");

    cov_tb_irq: cover property (tb_event ##2 timebase_irq);
    cov_capture: cover property (cap_edge && !cap_flag_reg ##[1:40] cap_rd);
    cov_wdg_reset: cover property (period_end && wdg_active ##1
        watchdog_reset);
    cov_halt_wake: cover property (halted_reg ##1 ext_wake);

endmodule : tbw_timer

// >>> tbw_timer_test.sv
// Self-checking bench for the timebase, watchdog and capture block.
// Assumes PRESCALE of 4, so one overflow every 1000 core_clk cycles.
`timescale 1ns/1ps
`define CHK(g, e) check_val(32'(g), 32'(e));
module tbw_timer_test;
    localparam int PRE = 4;
    localparam int OVF = PRE * 250;
    logic core_clk, rst, low_voltage_reset, capture_input_pin;
    logic hw_watchdog_opt, reset_on_halt_opt, halt_enter, ext_wake;
    tbw_pkg::tbw_bus_type bus;
    logic [7:0] rd_data, d;
    logic timebase_irq, capture_irq, watchdog_reset;
    int miscompares, checks_done;
    time t0, t1;

    tbw_timer #(.PRESCALE(PRE)) dut_u (
        .core_clk(core_clk), .rst(rst), .low_voltage_reset(low_voltage_reset),
        .bus(bus), .rd_data(rd_data), .capture_input_pin(capture_input_pin),
        .hw_watchdog_opt(hw_watchdog_opt),
        .reset_on_halt_opt(reset_on_halt_opt), .halt_enter(halt_enter),
        .ext_wake(ext_wake), .timebase_irq(timebase_irq),
        .capture_irq(capture_irq), .watchdog_reset(watchdog_reset)
    );

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task check_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val

    task summarize;
        $display("Checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    task rst_dut(input logic lv);
        @(posedge core_clk);
        rst <= 1'b1;
        low_voltage_reset <= lv;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        low_voltage_reset <= 1'b0;
        @(posedge core_clk);
    endtask : rst_dut

    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= v;
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge core_clk);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge core_clk);
        bus.rd <= 1'b0;
        #1 v = rd_data;
    endtask : rd

    task pulse(input int which);
        @(posedge core_clk);
        if (which == 0) halt_enter <= 1'b1;
        else ext_wake <= 1'b1;
        @(posedge core_clk);
        halt_enter <= 1'b0;
        ext_wake <= 1'b0;
    endtask : pulse

    // Clears the flag, then waits for the next timebase interrupt
    task tb_event(output time t);
        int n;
        rd(tbw_pkg::CSR_ADDR, d);
        repeat (3) @(posedge core_clk);
        #1;
        for (n = 0; n < 2500 && timebase_irq !== 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        t = $time;
    endtask : tb_event

    // No reset for quiet cycles, then one within span cycles if span > 0
    task wdg_window(input int quiet, input int span);
        int n;
        logic seen;
        seen = 1'b0;
        for (n = 0; n < quiet; n++) begin
            #1 if (watchdog_reset === 1'b1) seen = 1'b1;
            @(posedge core_clk);
        end
        `CHK(seen, 1'b0)
        if (span > 0) begin
            for (n = 0; n < span && !seen; n++) begin
                #1 seen = (watchdog_reset === 1'b1);
                @(posedge core_clk);
            end
            `CHK(seen, 1'b1)
        end
    endtask : wdg_window

    task test_regs;
        rst_dut(1'b1);
        rd(tbw_pkg::CSR_ADDR, d);
        `CHK(d, 8'h00)
        rd(tbw_pkg::CAP_ADDR, d);
        `CHK(d, 8'h00)
        wr(8'h0D, 8'hFF);
        rd(8'h0D, d);
        `CHK(d, 8'h00)
    endtask : test_regs

    task test_timebase;
        wr(tbw_pkg::CSR_ADDR, 8'h10);
        tb_event(t0);
        rd(tbw_pkg::CSR_ADDR, d);
        `CHK(d & 8'h18, 8'h18)
        repeat (3) @(posedge core_clk);
        `CHK(timebase_irq, 1'b0)
        wr(tbw_pkg::CSR_ADDR, 8'h18);
        rd(tbw_pkg::CSR_ADDR, d);
        `CHK(d[3], 1'b0)
        tb_event(t1);
        `CHK(t1 - t0, OVF * 100)
        wr(tbw_pkg::CSR_ADDR, 8'h30);
        tb_event(t0);
        tb_event(t1);
        `CHK(t1 - t0, 2 * OVF * 100)
    endtask : test_timebase

    task test_capture;
        wr(tbw_pkg::CSR_ADDR, 8'h90);
        rd(tbw_pkg::CAP_ADDR, d);
        tb_event(t0);
        repeat (41) @(posedge core_clk);
        capture_input_pin <= ~capture_input_pin;
        repeat (3) @(posedge core_clk);
        #1 `CHK(capture_irq, 1'b1)
        capture_input_pin <= ~capture_input_pin;
        repeat (20) @(posedge core_clk);
        wr(tbw_pkg::CAP_ADDR, 8'hFF);
        wr(tbw_pkg::CSR_ADDR, 8'h90);
        rd(tbw_pkg::CSR_ADDR, d);
        `CHK(d[6], 1'b1)
        rd(tbw_pkg::CAP_ADDR, d);
        `CHK(d, 8'h0A)
        wr(tbw_pkg::CSR_ADDR, 8'hD0);
        rd(tbw_pkg::CSR_ADDR, d);
        `CHK(d[6], 1'b0)
        repeat (2) @(posedge core_clk);
        `CHK(capture_irq, 1'b0)
    endtask : test_capture

    task test_watchdog;
        wr(tbw_pkg::CSR_ADDR, 8'h01);
        wr(tbw_pkg::CSR_ADDR, 8'h03);
        wdg_window(2 * OVF - 100, 2 * OVF + 300);
        rst_dut(1'b0);
        rd(tbw_pkg::CSR_ADDR, d);
        `CHK(d, 8'h04)
        wr(tbw_pkg::CSR_ADDR, 8'h00);
        rd(tbw_pkg::CSR_ADDR, d);
        `CHK(d, 8'h00)
        repeat (2 * OVF + 100) @(posedge core_clk);
        wr(tbw_pkg::CSR_ADDR, 8'h02);
        wdg_window(0, 3);
        rst_dut(1'b1);
        wr(tbw_pkg::CSR_ADDR, 8'h03);
        wr(tbw_pkg::CSR_ADDR, 8'h07);
        wdg_window(0, 3);
        rst_dut(1'b0);
        wr(tbw_pkg::CSR_ADDR, 8'h06);
        wdg_window(0, 3);
    endtask : test_watchdog

    task test_options;
        hw_watchdog_opt <= 1'b1;
        rst_dut(1'b1);
        wdg_window(2 * OVF - 100, 400);
        rst_dut(1'b1);
        repeat (100) @(posedge core_clk);
        wr(tbw_pkg::CSR_ADDR, 8'h01);
        pulse(0);
        wdg_window(3 * OVF, 0);
        pulse(1);
        wdg_window(4 * OVF - 100, 400);
        rst_dut(1'b1);
        reset_on_halt_opt <= 1'b1;
        repeat (50) @(posedge core_clk);
        pulse(0);
        wdg_window(0, 3);
    endtask : test_options

    initial begin
        miscompares = 0;
        checks_done = 0;
        rst = 1'b1;
        low_voltage_reset = 1'b1;
        bus = '0;
        capture_input_pin = 1'b0;
        hw_watchdog_opt = 1'b0;
        reset_on_halt_opt = 1'b0;
        halt_enter = 1'b0;
        ext_wake = 1'b0;
        test_regs();
        test_timebase();
        test_capture();
        test_watchdog();
        test_options();
        summarize();
    end

    // Cuts a hang short well past the expected run length
    initial begin
        #(64'd60000 * 100);
        miscompares++;
        summarize();
    end
endmodule : tbw_timer_test
